// file: core/sacq_params.svh
`ifndef SACQ_PARAMS_SVH
`define SACQ_PARAMS_SVH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SACQ_CLK_MHZ        250
`define SACQ_DEAD_TIME_US   1000
// ----------------------------------------------------------------
// limits of the setup fields
// ----------------------------------------------------------------
`define SACQ_REC_MIN        21'h000064
`define SACQ_REC_MAX        21'h1E8480
`define SACQ_PART_LOG_MAX   4'hC
`define SACQ_OFS_LIM        16'sh4E20
`define SACQ_THR_LIM        6'sh14
`define SACQ_GAIN_LAST      3'h6
`define SACQ_COARSE_CODE    3'h4
`define SACQ_TDIV_LAST      5'h1D
`define SACQ_SINT_LAST      5'h15
// ----------------------------------------------------------------
// repeat-acquisition bands
// ----------------------------------------------------------------
`define SACQ_RPT_BASE_CNT   13'h0064
`define SACQ_RPT_STEP_CNT   13'h00FA
`define SACQ_RPT_BASE_LEN   34'h0000F4240
`define SACQ_RPT_STEP_LEN   34'h0000186A0
`define SACQ_RPT_BANDS      10
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SACQ_RST_CNT        13'h0001
`define SACQ_RST_PART       4'h0
`endif

// file: core/sacq_pkg.sv
package sacq_pkg;
  typedef enum logic [2:0] {CPL_AC, CPL_DC, CPL_AC50, CPL_DC50, CPL_GND} sacq_cpl_t;
  typedef enum logic [1:0] {SCLK_INT, SCLK_EXT1M, SCLK_EXT50} sacq_sclk_t;
  typedef enum logic [1:0] {REF_INT, REF_EXT1M, REF_EXT50, REF_BACKPLANE_SRC} sacq_ref_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_CAPT, ST_DEAD, ST_READ} sacq_state_t;

  typedef struct packed {
    logic               scope_mode;  // 1 oscilloscope, 0 digitizer
    logic [1:0]         probe;       // 1:1, 10:1, 100:1, 1000:1
    sacq_cpl_t          cpl;
    logic [2:0]         gain;        // sensitivity or range code
    logic signed [15:0] ofs;         // 0.1 mV fine, 1 mV coarse
    logic [4:0]         tbase;       // time/div or interval code
    sacq_sclk_t         sclk;
    sacq_ref_t          rsrc;
    logic signed [5:0]  thr;         // 0.1 V units
    logic [3:0]         part_log;
    logic [20:0]        rec_len;
    logic [12:0]        acq_cnt;
    logic               trig_normal;
    logic               repeat_en;
  } sacq_cfg_t;

  typedef struct packed {
    logic [11:0] blk;
    logic [7:0]  code;
  } sacq_smp_t;
endpackage

// file: core/sacq_top.sv
`timescale 1ns/1ns
`include "sacq_params.svh"

// ----------------------------------------------------------------
// sample buffer
// ----------------------------------------------------------------
module sacq_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0]  wr_reg;
  logic [AW:0]  rd_reg;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem_reg[rd_reg[AW-1:0]];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem_reg[wr_reg[AW-1:0]] <= in_data;
  end
endmodule

// ----------------------------------------------------------------
// acquisition setup and sequencing
// ----------------------------------------------------------------
// Functional notes
// RL1: memory splits into power-of-two blocks up to 4096, filled in turn per trigger
// RL2: unpartitioned record length runs from 100 to 2000000 points
// RL3: record length upper limit shrinks with partition count; 4096 blocks allow only 100
// RL4: acquisition count runs 1 to partitions; only in normal trigger when partitioned
// RL5: count above one means sequential store, readout after all blocks captured
// RL6: dead time between sequential captures is about one millisecond
// RL7: count of one is single capture; repeat loops capture and readout until stopped
// RL8: repeat is refused when count times length exceeds the band limit
// RL9: digitizer sampling interval is 1-2-5 from 1 ns to 10 ms
// RL10: scope time/div 10 ns to 50 s, ignored unless the sampling clock is internal
// RL11: external sampling clock only with internal reference, normal trigger, 10-500 MHz
// RL12: reference clock is internal, external 1M, external 50 or backplane
// RL13: external threshold is -2.0 to 2.0 V in 0.1 V steps
// RL14: overvoltage on 50 ohm coupling switches coupling to ground
// RL15: overvoltage on the 50 ohm clock input switches the clock to 1M input
// RL16: probe factors 1, 10, 100, 1000 scale displayed sensitivity and offset
// RL17: offset only with DC coupling, +-2 V fine or +-20 V coarse
// RL18: digitizer offers seven ranges from 25 mV to 2.5 V
// RL19: scope sensitivity is 1-2-5 from 5 mV/div to 500 mV/div
// RL20: mode changes are refused while acquisition runs
// RL21: illegal setup combinations are refused or clamped before acquisition
module sacq_top import sacq_pkg::*; #(
  parameter int DEAD_CYC = `SACQ_DEAD_TIME_US * `SACQ_CLK_MHZ,
  parameter int DEPTH    = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire sacq_cfg_t  cfg_in,
  input  wire logic       cfg_apply,
  output sacq_cfg_t       cfg_active,
  output logic            cfg_refused,
  output logic            cfg_clamped,
  input  wire logic       ext_clk_ok,
  input  wire logic       ovp_input,
  input  wire logic       ovp_clk_in,
  input  wire logic       acq_start,
  input  wire logic       acq_stop,
  input  wire logic       trig,
  input  wire logic       smp_valid,
  output logic            smp_ready,
  input  wire logic [7:0] smp_code,
  output logic            out_valid,
  input  wire logic       out_ready,
  output sacq_smp_t       out_smp,
  output logic            readout_req,
  input  wire logic       readout_done,
  output logic            busy,
  output logic            seq_mode,
  output logic            repeat_ok,
  output logic            ofs_coarse,
  output logic            tbase_used,
  output logic            thr_used,
  output logic [9:0]      probe_mult,
  output logic [11:0]     blk_idx
);
  localparam int DW = $clog2(DEAD_CYC + 1);
  localparam sacq_cfg_t CFG_RST = '{scope_mode: 1'b1, probe: 2'h0, cpl: CPL_DC, gain: 3'h0,
                                    ofs: 16'sh0000, tbase: 5'h00, sclk: SCLK_INT, rsrc: REF_INT,
                                    thr: 6'sh00, part_log: `SACQ_RST_PART, rec_len: `SACQ_REC_MIN,
                                    acq_cnt: `SACQ_RST_CNT, trig_normal: 1'b0, repeat_en: 1'b0};

  function automatic logic [20:0] max_rec(input logic [3:0] pl);
    unique case (pl)
      4'h0:    max_rec = `SACQ_REC_MAX;
      4'h1:    max_rec = 21'h0F4240;
      4'h2:    max_rec = 21'h07EF40;
      4'h3:    max_rec = 21'h03A980;
      4'h4:    max_rec = 21'h01D4C0;
      4'h5:    max_rec = 21'h00FA00;
      4'h6:    max_rec = 21'h007D00;
      4'h7:    max_rec = 21'h003E80;
      4'h8:    max_rec = 21'h001C20;
      4'h9:    max_rec = 21'h000E10;
      4'hA:    max_rec = 21'h000640;
      4'hB:    max_rec = 21'h000258;
      default: max_rec = `SACQ_REC_MIN;
    endcase
  endfunction

  // counts beyond the last band keep the smallest limit
  function automatic logic [33:0] rpt_limit(input logic [12:0] cnt);
    logic [12:0] edge_cnt;
    rpt_limit = `SACQ_RPT_BASE_LEN;
    edge_cnt  = `SACQ_RPT_BASE_CNT;
    for (int i = 1; i < `SACQ_RPT_BANDS; i++) begin
      if (cnt > edge_cnt) rpt_limit = rpt_limit - `SACQ_RPT_STEP_LEN;
      edge_cnt = edge_cnt + `SACQ_RPT_STEP_CNT;
    end
  endfunction

  function automatic logic is50(input sacq_cpl_t c);
    is50 = (c == CPL_AC50) || (c == CPL_DC50);
  endfunction

  // ----------------------------------------------------------------
  // setup check and clamp
  // ----------------------------------------------------------------
  sacq_cfg_t   cfg_reg;
  sacq_cfg_t   cfg_fix;
  sacq_cfg_t   cfg_sel;
  sacq_state_t state_reg;
  logic [12:0] done_reg;
  logic [20:0] scnt_reg;
  logic [DW-1:0] dead_reg;
  logic        fifo_in_ready;

  wire         apply_ok  = cfg_apply && !busy;  // RL20
  wire  [3:0]  part_fix  = (cfg_in.part_log > `SACQ_PART_LOG_MAX) ? `SACQ_PART_LOG_MAX : cfg_in.part_log;
  wire  [20:0] rec_hi    = max_rec(part_fix);
  wire  [12:0] parts_fix = 13'h0001 << part_fix;
  wire         dc_cpl    = (cfg_in.cpl == CPL_DC) || (cfg_in.cpl == CPL_DC50);
  wire  [4:0]  tb_last   = cfg_in.scope_mode ? `SACQ_TDIV_LAST : `SACQ_SINT_LAST;
  wire         ext_ok    = (cfg_in.rsrc == REF_INT) && cfg_in.trig_normal && ext_clk_ok;
  wire         cnt_free  = cfg_in.trig_normal && (part_fix != 4'h0);

  assign cfg_fix.scope_mode  = cfg_in.scope_mode;
  assign cfg_fix.probe       = cfg_in.probe;
  assign cfg_fix.cpl         = (cfg_in.cpl > CPL_GND) ? CPL_GND : cfg_in.cpl;
  assign cfg_fix.gain        = (cfg_in.gain > `SACQ_GAIN_LAST) ? `SACQ_GAIN_LAST : cfg_in.gain; // RL18 RL19
  assign cfg_fix.ofs         = !dc_cpl ? 16'sh0000 :                                              // RL17
                               (cfg_in.ofs > `SACQ_OFS_LIM) ? `SACQ_OFS_LIM :
                               (cfg_in.ofs < -`SACQ_OFS_LIM) ? -`SACQ_OFS_LIM : cfg_in.ofs;
  assign cfg_fix.tbase       = (cfg_in.tbase > tb_last) ? tb_last : cfg_in.tbase;               // RL9 RL10
  assign cfg_fix.sclk        = (ext_ok && cfg_in.sclk <= SCLK_EXT50) ? cfg_in.sclk : SCLK_INT;   // RL11
  assign cfg_fix.rsrc        = cfg_in.rsrc;                                                       // RL12
  assign cfg_fix.thr         = (cfg_in.thr > `SACQ_THR_LIM) ? `SACQ_THR_LIM :                     // RL13
                               (cfg_in.thr < -`SACQ_THR_LIM) ? -`SACQ_THR_LIM : cfg_in.thr;
  assign cfg_fix.part_log    = part_fix;                                                          // RL1
  assign cfg_fix.rec_len     = (cfg_in.rec_len < `SACQ_REC_MIN) ? `SACQ_REC_MIN :                 // RL2 RL3
                               (cfg_in.rec_len > rec_hi) ? rec_hi : cfg_in.rec_len;
  assign cfg_fix.acq_cnt     = !cnt_free ? 13'h0001 :                                             // RL4
                               (cfg_in.acq_cnt == 13'h0000) ? 13'h0001 :
                               (cfg_in.acq_cnt > parts_fix) ? parts_fix : cfg_in.acq_cnt;
  assign cfg_fix.trig_normal = cfg_in.trig_normal;
  assign cfg_fix.repeat_en   = cfg_in.repeat_en;

  assign cfg_sel = apply_ok ? cfg_fix : cfg_reg;  // RL21

  // protection fallbacks act even mid-acquisition and win over an apply
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_reg     <= CFG_RST;
      cfg_refused <= 1'b0;
      cfg_clamped <= 1'b0;
    end else begin
      cfg_reg     <= cfg_sel;
      cfg_refused <= cfg_apply && busy;
      cfg_clamped <= apply_ok && (cfg_fix != cfg_in);
      if (ovp_input && is50(cfg_sel.cpl)) cfg_reg.cpl <= CPL_GND;                  // RL14
      if (ovp_clk_in && cfg_sel.sclk == SCLK_EXT50) cfg_reg.sclk <= SCLK_EXT1M;    // RL15
    end
  end

  // ----------------------------------------------------------------
  // derived status
  // ----------------------------------------------------------------
  wire [33:0] total_len = 34'(cfg_reg.acq_cnt) * 34'(cfg_reg.rec_len);
  wire [11:0] blk_mask  = 12'((13'h0001 << cfg_reg.part_log) - 13'h0001);

  assign cfg_active = cfg_reg;
  assign repeat_ok  = total_len <= rpt_limit(cfg_reg.acq_cnt);   // RL8
  assign seq_mode   = cfg_reg.acq_cnt > 13'h0001;                // RL5
  assign ofs_coarse = cfg_reg.gain >= `SACQ_COARSE_CODE;         // RL17
  assign tbase_used = cfg_reg.sclk == SCLK_INT;                  // RL10
  assign thr_used   = (cfg_reg.sclk != SCLK_INT) ||              // RL13
                      (cfg_reg.rsrc == REF_EXT1M) || (cfg_reg.rsrc == REF_EXT50);
  assign probe_mult = (cfg_reg.probe == 2'h0) ? 10'h001 : (cfg_reg.probe == 2'h1) ? 10'h00A :  // RL16
                      (cfg_reg.probe == 2'h2) ? 10'h064 : 10'h3E8;
  assign busy        = state_reg != ST_IDLE;
  assign readout_req = state_reg == ST_READ;

  // ----------------------------------------------------------------
  // capture sequencer
  // ----------------------------------------------------------------
  wire        push      = smp_valid && smp_ready;
  wire        last_smp  = push && (scnt_reg == cfg_reg.rec_len - 21'h000001);
  wire [12:0] done_inc  = done_reg + 13'h0001;
  wire        more_blk  = done_inc < cfg_reg.acq_cnt;
  wire        again     = cfg_reg.repeat_en && repeat_ok;        // RL7 RL8

  assign smp_ready = (state_reg == ST_CAPT) && fifo_in_ready;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      blk_idx   <= '0;
      done_reg  <= '0;
      scnt_reg  <= '0;
      dead_reg  <= '0;
    end else if (acq_stop) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (acq_start) begin
          state_reg <= ST_ARMED;
          blk_idx   <= '0;
          done_reg  <= '0;
        end
        ST_ARMED: if (trig) begin
          state_reg <= ST_CAPT;
          scnt_reg  <= '0;
        end
        ST_CAPT: begin
          if (push) scnt_reg <= scnt_reg + 21'h000001;
          if (last_smp) begin
            done_reg  <= done_inc;
            state_reg <= more_blk ? ST_DEAD : ST_READ;                          // RL5
            dead_reg  <= DW'(DEAD_CYC - 1);                                     // RL6
            if (more_blk) blk_idx <= (blk_idx + 12'h001) & blk_mask;           // RL1
          end
        end
        ST_DEAD: begin
          dead_reg <= dead_reg - 1'b1;
          if (dead_reg == '0) state_reg <= ST_ARMED;                            // RL6
        end
        ST_READ: if (readout_done) begin
          state_reg <= again ? ST_ARMED : ST_IDLE;                              // RL7
          blk_idx   <= '0;
          done_reg  <= '0;
        end
      endcase
    end
  end

  sacq_fifo #(.W($bits(sacq_smp_t)), .DEPTH(DEPTH)) u_sacq_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (smp_valid && state_reg == ST_CAPT),
    .in_ready  (fifo_in_ready),
    .in_data   ({blk_idx, smp_code}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_smp)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_ovp_to_gnd: assert property (ovp_input && is50(cfg_sel.cpl) |=> cfg_reg.cpl == CPL_GND) // RL14
    else $error("coupling did not fall back to ground");
  a_ovp_clk_fallback: assert property (ovp_clk_in && cfg_sel.sclk == SCLK_EXT50 |=> cfg_reg.sclk == SCLK_EXT1M) // RL15
    else $error("clock source did not fall back to 1M");
  a_rec_len_range: assert property (cfg_reg.rec_len >= `SACQ_REC_MIN && // RL3
                                    cfg_reg.rec_len <= max_rec(cfg_reg.part_log))
    else $error("record length outside partition limit");
  a_acq_cnt_range: assert property (cfg_reg.acq_cnt >= 13'h0001 && // RL4
                                    cfg_reg.acq_cnt <= (13'h0001 << cfg_reg.part_log))
    else $error("acquisition count outside range");
  a_mode_locked: assert property (busy |=> $stable(cfg_reg.scope_mode)) // RL20
    else $error("mode changed during acquisition");
  a_ext_clk_gate: assert property (cfg_reg.sclk != SCLK_INT |-> cfg_reg.rsrc == REF_INT && cfg_reg.trig_normal) // RL11
    else $error("external sampling clock with illegal reference or trigger");
  a_offset_dc_only: assert property (cfg_reg.cpl == CPL_AC || cfg_reg.cpl == CPL_AC50 // RL17
                                     |-> cfg_reg.ofs == 16'sh0000)
    else $error("offset applied without DC coupling");
  a_dead_hold: assert property (state_reg == ST_CAPT && last_smp && more_blk && !acq_stop // RL6
                                |=> (state_reg == ST_DEAD) [*2])
    else $error("dead time cut short");
  a_blk_advance: assert property (state_reg == ST_CAPT && last_smp && more_blk && !acq_stop // RL1
                                  |=> blk_idx == (($past(blk_idx) + 12'h001) & blk_mask))
    else $error("block index did not advance");
  a_repeat_refused: assert property (state_reg == ST_READ && readout_done && !acq_stop && !again // RL8
                                     |=> state_reg == ST_IDLE)
    else $error("repeat taken when refused");
endmodule

// file: tb/sacq_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// far side: sample source, stallable sink, slow readout acknowledge
// ----------------------------------------------------------------
module sacq_host_model import sacq_pkg::*; (
  input  wire logic      clk_sys,
  input  wire logic      resetn,
  input  wire logic      stall,
  input  wire logic      smp_ready,
  output logic           smp_valid,
  output logic [7:0]     smp_code,
  input  wire logic      out_valid,
  output logic           out_ready,
  input  wire sacq_smp_t out_smp,
  input  wire logic      readout_req,
  output logic           readout_done,
  output logic [15:0]    n0,
  output logic [15:0]    n1
);
  logic [1:0] wait_reg;
  // source always offers data; code moves only on a taken sample
  assign smp_valid = resetn;
  assign out_ready = !stall;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      smp_code     <= 8'h00;
      n0           <= 16'h0000;
      n1           <= 16'h0000;
      wait_reg     <= 2'h0;
      readout_done <= 1'b0;
    end else begin
      if (smp_valid && smp_ready)
        smp_code <= smp_code + 8'h01;
      if (out_valid && out_ready && out_smp.blk == 12'h000)
        n0 <= n0 + 16'h0001;
      if (out_valid && out_ready && out_smp.blk != 12'h000)
        n1 <= n1 + 16'h0001;
      // host takes a few cycles before it reports the readout finished
      if (readout_req && !readout_done) begin
        wait_reg     <= wait_reg + 2'h1;
        readout_done <= (wait_reg == 2'h3);
      end else begin
        wait_reg     <= 2'h0;
        readout_done <= 1'b0;
      end
    end
  end
endmodule

// file: tb/sacq_top_tb.sv
`timescale 1ns/1ns
module sacq_top_tb;
  import sacq_pkg::*;
  localparam int DEAD = 4;
  logic       clk_sys = 1'b0, resetn = 1'b0, cfg_apply = 1'b0, cfg_refused, cfg_clamped;
  logic       ext_clk_ok = 1'b1, ovp_input = 1'b0, ovp_clk_in = 1'b0, stall = 1'b0;
  logic       acq_start = 1'b0, acq_stop = 1'b0, trig = 1'b0, smp_valid, smp_ready, out_valid, out_ready;
  logic       readout_req, readout_done, busy, seq_mode, repeat_ok, ofs_coarse, tbase_used, thr_used;
  logic [7:0] smp_code;
  logic [9:0] probe_mult;
  logic [11:0] blk_idx;
  logic [15:0] n0, n1;
  sacq_cfg_t  cfg_in = '0, cfg_active, c;
  sacq_smp_t  out_smp;
  int         fail_count = 0, checks = 0;
  logic [20:0] lim [0:12] = '{21'h1E8480, 21'h0F4240, 21'h07EF40, 21'h03A980, 21'h01D4C0, 21'h00FA00,
                              21'h007D00, 21'h003E80, 21'h001C20, 21'h000E10, 21'h000640, 21'h000258, 21'h000064};
  logic [9:0] mult [0:3] = '{10'h001, 10'h00A, 10'h064, 10'h3E8};

  always #2 clk_sys = ~clk_sys;

  sacq_top #(.DEAD_CYC(DEAD), .DEPTH(8)) u_sacq_top (.clk_sys(clk_sys), .resetn(resetn), .cfg_in(cfg_in),
    .cfg_apply(cfg_apply), .cfg_active(cfg_active), .cfg_refused(cfg_refused), .cfg_clamped(cfg_clamped),
    .ext_clk_ok(ext_clk_ok), .ovp_input(ovp_input), .ovp_clk_in(ovp_clk_in), .acq_start(acq_start),
    .acq_stop(acq_stop), .trig(trig), .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_code(smp_code),
    .out_valid(out_valid), .out_ready(out_ready), .out_smp(out_smp), .readout_req(readout_req),
    .readout_done(readout_done), .busy(busy), .seq_mode(seq_mode), .repeat_ok(repeat_ok),
    .ofs_coarse(ofs_coarse), .tbase_used(tbase_used), .thr_used(thr_used), .probe_mult(probe_mult),
    .blk_idx(blk_idx));

  sacq_host_model u_sacq_host_model (.clk_sys(clk_sys), .resetn(resetn), .stall(stall),
    .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_code(smp_code), .out_valid(out_valid),
    .out_ready(out_ready), .out_smp(out_smp), .readout_req(readout_req), .readout_done(readout_done),
    .n0(n0), .n1(n1));

  task automatic close_out;
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // plain legal setup: scope, dc, 100 points, one capture, normal trigger
  task automatic base;
    c = '0;
    c.scope_mode = 1'b1;
    c.cpl = CPL_DC;
    c.rec_len = 21'h000064;
    c.acq_cnt = 13'h0001;
    c.trig_normal = 1'b1;
  endtask

  task automatic apply;
    @(posedge clk_sys);
    cfg_in <= c;
    cfg_apply <= 1'b1;
    @(posedge clk_sys);
    cfg_apply <= 1'b0;
    #1;
  endtask

  // 0 start, 1 stop, 2 trigger, 3 input overvoltage, 4 clock overvoltage
  task automatic pulse(input int k);
    @(posedge clk_sys);
    case (k)
      0: acq_start <= 1'b1;
      1: acq_stop <= 1'b1;
      2: trig <= 1'b1;
      3: ovp_input <= 1'b1;
      default: ovp_clk_in <= 1'b1;
    endcase
    @(posedge clk_sys);
    {acq_start, acq_stop, trig, ovp_input, ovp_clk_in} <= 5'h00;
    #1;
  endtask

  task automatic wait_rd;
    for (int i = 0; i < 3000 && readout_req !== 1'b1; i++)
      @(posedge clk_sys);
    #1;
  endtask

  initial begin
    tick(5);
    @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk("rst_rec_len", 32'h64, 32'(cfg_active.rec_len));
    chk("rst_acq_cnt", 32'h1, 32'(cfg_active.acq_cnt));
    chk("rst_busy", 32'h0, 32'(busy));
    chk("rst_blk", 32'h0, 32'(blk_idx));
    for (int p = 0; p < 13; p++) begin
      base;
      c.part_log = p[3:0];
      c.rec_len = lim[p];
      apply;
      chk("rec_len_max", 32'(lim[p]), 32'(cfg_active.rec_len));
      chk("no_clamp", 32'h0, 32'(cfg_clamped));
      c.rec_len = lim[p] + 21'h000001;
      apply;
      chk("rec_len_over", 32'(lim[p]), 32'(cfg_active.rec_len));
      chk("clamp_pulse", 32'h1, 32'(cfg_clamped));
    end
    base;
    c.part_log = 4'hD;
    c.rec_len = 21'h000063;
    apply;
    chk("part_max", 32'hC, 32'(cfg_active.part_log));
    chk("rec_len_min", 32'h64, 32'(cfg_active.rec_len));
    base;
    c.part_log = 4'h2;
    c.acq_cnt = 13'h0005;
    apply;
    chk("cnt_part", 32'h4, 32'(cfg_active.acq_cnt));
    c.trig_normal = 1'b0;
    apply;
    chk("cnt_auto", 32'h1, 32'(cfg_active.acq_cnt));
    base;
    c.part_log = 4'h2;
    c.acq_cnt = 13'h0000;
    apply;
    chk("cnt_zero", 32'h1, 32'(cfg_active.acq_cnt));
    base;
    c.part_log = 4'h7;
    c.acq_cnt = 13'h0064;
    c.rec_len = 21'h002710;
    apply;
    chk("rpt_band0", 32'h1, 32'(repeat_ok));
    chk("seq_mode", 32'h1, 32'(seq_mode));
    c.rec_len = 21'h002711;
    apply;
    chk("rpt_band0_over", 32'h0, 32'(repeat_ok));
    c.acq_cnt = 13'h0065;
    c.rec_len = 21'h0022C4;
    apply;
    chk("rpt_band1", 32'h1, 32'(repeat_ok));
    c.rec_len = 21'h002328;
    apply;
    chk("rpt_band1_over", 32'h0, 32'(repeat_ok));
    for (int p = 0; p < 4; p++) begin
      base;
      c.probe = p[1:0];
      c.rsrc = sacq_ref_t'(p[1:0]);
      apply;
      chk("probe_mult", 32'(mult[p]), 32'(probe_mult));
      chk("ref_src", p, 32'(cfg_active.rsrc));
      chk("thr_sel", 32'(p == 1 || p == 2), 32'(thr_used));
      chk("ofs_fine", 32'h0, 32'(ofs_coarse));
    end
    base;
    c.sclk = SCLK_EXT50;
    c.rsrc = REF_EXT1M;
    apply;
    chk("sclk_ref_ext", 32'(SCLK_INT), 32'(cfg_active.sclk));
    base;
    c.sclk = SCLK_EXT50;
    ext_clk_ok <= 1'b0;
    apply;
    chk("sclk_freq_bad", 32'(SCLK_INT), 32'(cfg_active.sclk));
    ext_clk_ok <= 1'b1;
    apply;
    chk("sclk_ext", 32'(SCLK_EXT50), 32'(cfg_active.sclk));
    chk("tbase_void", 32'h0, 32'(tbase_used));
    chk("thr_used", 32'h1, 32'(thr_used));
    pulse(4);
    chk("clk_ovp", 32'(SCLK_EXT1M), 32'(cfg_active.sclk));
    base;
    c.cpl = CPL_AC;
    c.ofs = 16'sh0064;
    c.thr = 6'sh1E;
    c.gain = 3'h7;
    c.tbase = 5'h1E;
    apply;
    chk("ofs_ac", 32'h0, 32'(cfg_active.ofs));
    chk("thr_hi", 32'h14, 32'(cfg_active.thr));
    chk("gain_max", 32'h6, 32'(cfg_active.gain));
    chk("tdiv_max", 32'h1D, 32'(cfg_active.tbase));
    chk("tbase_used", 32'h1, 32'(tbase_used));
    base;
    c.cpl = CPL_DC50;
    c.ofs = 16'sh7530;
    c.thr = 6'sh22;
    c.gain = 3'h4;
    c.scope_mode = 1'b0;
    c.tbase = 5'h16;
    apply;
    chk("ofs_max", 32'h4E20, 32'(cfg_active.ofs));
    chk("ofs_coarse", 32'h1, 32'(ofs_coarse));
    chk("thr_lo", 32'hFFFFFFEC, 32'(cfg_active.thr));
    chk("sint_max", 32'h15, 32'(cfg_active.tbase));
    pulse(3);
    chk("in_ovp", 32'(CPL_GND), 32'(cfg_active.cpl));
    base;
    c.part_log = 4'h1;
    c.acq_cnt = 13'h0002;
    apply;
    pulse(2);
    chk("trig_idle", 32'h0, 32'(busy));
    @(posedge clk_sys);
    stall <= 1'b1;
    pulse(0);
    tick(2);
    pulse(2);
    tick(14);
    chk("fifo_full", 32'h0, 32'(smp_ready));
    chk("fifo_valid", 32'h1, 32'(out_valid));
    @(posedge clk_sys);
    stall <= 1'b0;
    c.scope_mode = 1'b0;
    apply;
    chk("refused", 32'h1, 32'(cfg_refused));
    chk("mode_kept", 32'h1, 32'(cfg_active.scope_mode));
    for (int i = 0; i < 3000 && blk_idx !== 12'h001; i++)
      @(posedge clk_sys);
    tick(DEAD + 4);
    chk("blk_next", 32'h1, 32'(blk_idx));
    chk("rd_deferred", 32'h0, 32'(readout_req));
    pulse(2);
    wait_rd;
    chk("rd_req", 32'h1, 32'(readout_req));
    tick(14);
    chk("blk0_cnt", 32'h64, 32'(n0));
    chk("blk1_cnt", 32'h64, 32'(n1));
    chk("fifo_empty", 32'h0, 32'(out_valid));
    chk("done_idle", 32'h0, 32'(busy));
    base;
    c.repeat_en = 1'b1;
    apply;
    chk("single_mode", 32'h0, 32'(seq_mode));
    pulse(0);
    tick(2);
    pulse(2);
    wait_rd;
    chk("single_rd", 32'h1, 32'(readout_req));
    tick(8);
    chk("rpt_busy", 32'h1, 32'(busy));
    chk("rpt_rearm", 32'h0, 32'(readout_req));
    pulse(2);
    wait_rd;
    chk("rpt_rd", 32'h1, 32'(readout_req));
    pulse(1);
    chk("stopped", 32'h0, 32'(busy));
    close_out;
  end

  initial begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule
